//--- include/pmux_pkg.sv
// constants, field layouts and signal numbering for the peripheral pin multiplexer
// What this block does
// - Every peripheral signal sits in one of four groups and may only reach pins whose index modulo four equals its group.
// - Software picks, per pin, which permitted peripheral signal drives or reads it, so peripherals can move between pin positions.
// - Each pad is set to input only, output only or bidirectional.
// - After reset every pin is an undriven input until the multiplexer is enabled.
// - Enabling the multiplexer loads each pin with the default assignment of the selected package.
// - The 32, 48 and 64 pin packages offer 12, 28 and 44 configurable pins; any fitting mix is allowed except sync FIFO signals on 32 pins.
// - Writes selecting the synchronous FIFO signals are refused on the 32 pin package; a switch to it while enabled leaves earlier selections routed.
// - Routing is sized for serial 9, each SPI slave 4, SPI master 5, async FIFO 12, sync FIFO 14, GPIO 40, debug 1, PWM 8 signals.
// - A peripheral may be mapped only in part, its other signals staying off every pin.
// - The debug line defaults to pin 0 on every package, and any other group 0 signal may take that pin instead.
// - On the 64 pin package the defaults put FIFO data 0..7 on pins 4..11 and the five FIFO strobes on pins 12..16.
package pmux_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_PINS = 44;
	localparam int NUM_SIGS = 96;
	localparam int SEL_W    = 7;
	localparam int PIN_W    = 6;
	localparam int CFG_W    = 10;

	// ==========================================================
	// package codes and pin counts
	localparam logic [1:0] PKG_32        = 2'h0;
	localparam logic [1:0] PKG_48        = 2'h1;
	localparam logic [1:0] PKG_64        = 2'h2;
	localparam logic [1:0] PKG_RESET     = 2'h2;
	localparam logic [PIN_W-1:0] PINS_32 = 6'h0C;
	localparam logic [PIN_W-1:0] PINS_48 = 6'h1C;
	localparam logic [PIN_W-1:0] PINS_64 = 6'h2C;
	localparam logic [PIN_W-1:0] LAST_PIN = 6'h2B;

	// ==========================================================
	// signal numbering; each block starts on a multiple of four so
	// that signal number modulo four is its group
	localparam logic [SEL_W-1:0] SIG_DEBUG      = 7'h00;
	localparam logic [SEL_W-1:0] SIG_UART_BASE  = 7'h04; // 9 signals
	localparam logic [SEL_W-1:0] SIG_SPIS0_BASE = 7'h10; // 4 signals
	localparam logic [SEL_W-1:0] SIG_SPIS1_BASE = 7'h14; // 4 signals
	localparam logic [SEL_W-1:0] SIG_SPIM_BASE  = 7'h18; // 5 signals
	localparam logic [SEL_W-1:0] SIG_FIFO_BASE  = 7'h20; // 12 async + 2
	localparam logic [SEL_W-1:0] SIG_FIFO_SYNC0 = 7'h2C; // sync only
	localparam logic [SEL_W-1:0] SIG_FIFO_SYNC1 = 7'h2D; // sync only
	localparam logic [SEL_W-1:0] SIG_GPIO_BASE  = 7'h30; // 40 signals
	localparam logic [SEL_W-1:0] SIG_PWM_BASE   = 7'h58; // 8 signals

	// level seen by unrouted peripheral inputs: active-low lines idle high
	localparam logic [NUM_SIGS-1:0] IN_IDLE = 96'h0000_0000_0000_0C00_0088_0E80;

	// ==========================================================
	// pad direction codes
	localparam logic [1:0] DIR_IN    = 2'h0;
	localparam logic [1:0] DIR_OUT   = 2'h1;
	localparam logic [1:0] DIR_BIDIR = 2'h2;

	// ==========================================================
	// register map and fields
	localparam logic [8:0] ADDR_CTRL   = 9'h000;
	localparam logic [8:0] ADDR_STATUS = 9'h004;
	localparam int PINCFG_BIT          = 8;
	localparam int CTRL_EN_BIT         = 0;
	localparam int CTRL_PKG_LSB        = 1;
	localparam int ST_LOADING_BIT      = 0;
	localparam int ST_ACTIVE_BIT       = 1;
	localparam int ST_REJECT_BIT       = 2;
	localparam int CFG_VALID_BIT       = 7;
	localparam int CFG_DIR_LSB         = 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PMUX_IDLE, PMUX_LOAD, PMUX_RUN} pmux_state_t;

endpackage : pmux_pkg

//--- core/pmux_default_rom.sv
// default pin assignment table per package, registered read
`timescale 1ns/10ps
`default_nettype none
module pmux_default_rom
	import pmux_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [1:0]       pkgSel,
	input  wire logic [PIN_W-1:0] addr,
	output logic      [CFG_W-1:0] rdData_q
);

	// ==========================================================
	// entry = {dir, valid, select}; routed defaults are bidirectional so
	// the peripheral's own enable decides when the pad drives
	function automatic logic [CFG_W-1:0] entry(input logic [1:0] pkg, input logic [PIN_W-1:0] a);
		logic [SEL_W-1:0] s;
		logic             v;
		logic [SEL_W-1:0] a7;
		s  = SIG_DEBUG;
		v  = 1'b0;
		a7 = {1'b0, a};
		if (a == 6'h00) begin
			v = 1'b1;
		end else if (pkg == PKG_64) begin
			if (a >= 6'h04 && a <= 6'h10) begin
				s = SEL_W'(SIG_FIFO_BASE + a7 - 7'h04);
				v = 1'b1;
			end else if (a >= 6'h14 && a <= 6'h1C) begin
				s = SEL_W'(SIG_UART_BASE + a7 - 7'h14);
				v = 1'b1;
			end else if (a >= 6'h20 && a <= LAST_PIN) begin
				s = SEL_W'(SIG_SPIS0_BASE + a7 - 7'h20); // slaves and master are contiguous
				v = 1'b1;
			end
		end else if (pkg == PKG_48) begin
			v = (a < PINS_48);
			if (a <= 6'h03) s = SEL_W'(SIG_PWM_BASE + a7);
			else if (a <= 6'h07) s = SEL_W'(SIG_SPIS0_BASE + a7 - 7'h04);
			else if (a <= 6'h0B) s = SEL_W'(SIG_SPIM_BASE + a7 - 7'h08);
			else if (a <= 6'h14) s = SEL_W'(SIG_UART_BASE + a7 - 7'h0C);
			else if (a <= 6'h17) s = SEL_W'(SIG_GPIO_BASE + a7 - 7'h10);
			else s = SEL_W'(SIG_GPIO_BASE + a7 - 7'h18);
		end else begin
			v = (a < PINS_32);
			if (a <= 6'h03) s = SEL_W'(SIG_GPIO_BASE + a7);
			else if (a <= 6'h07) s = SEL_W'(SIG_UART_BASE + a7 - 7'h04);
			else s = SEL_W'(SIG_SPIS0_BASE + a7 - 7'h08);
		end
		entry = v ? {DIR_BIDIR, 1'b1, s} : {DIR_IN, 1'b0, SIG_DEBUG};
	endfunction : entry

	// ==========================================================
	// registered read port
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdData_q <= '0;
		end else begin
			rdData_q <= entry(pkgSel, addr);
		end
	end

endmodule : pmux_default_rom
`default_nettype wire

//--- core/pmux_top.sv
// peripheral pin multiplexer: AXI4-Lite registers, default loader and pin routing
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module pmux_top
	import pmux_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic [8:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [8:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [NUM_SIGS-1:0] periphOut,
	input  wire logic [NUM_SIGS-1:0] periphOe,
	output logic      [NUM_SIGS-1:0] periphIn,
	input  wire logic [NUM_PINS-1:0] pinIn,
	output logic      [NUM_PINS-1:0] pinOut,
	output logic      [NUM_PINS-1:0] pinOeN
);

	// ==========================================================
	// state
	pmux_state_t      state_q;
	logic             ctrlEn_q;
	logic [1:0]       ctrlPkg_q;
	logic             reject_q;
	logic [PIN_W-1:0] loadCnt_q;
	logic [PIN_W-1:0] loadWrIdx_q;
	logic             loadWrEn_q;
	logic [CFG_W-1:0] romData;
	logic [SEL_W-1:0] cfgSel_q [NUM_PINS];
	logic             cfgVal_q [NUM_PINS];
	logic [1:0]       cfgDir_q [NUM_PINS];
	logic             awHave_q, wHave_q;
	logic [8:0]       awAddr_q;
	logic [31:0]      wData_q;
	logic             stRun, stLoad, loadIssue, doWrite;
	logic [PIN_W-1:0] pinCount, wrPin, rdPin;
	logic             wrIsCfg, cfgOk, ctrlOk, wrOk;
	logic [SEL_W-1:0] wrSel;
	logic             wrVal;
	logic [1:0]       wrDir;
	logic [31:0]      rdWord;
	logic             rdOk;

	assign stRun     = (state_q == PMUX_RUN);
	assign stLoad    = (state_q == PMUX_LOAD);
	assign loadIssue = stLoad && (loadCnt_q <= LAST_PIN);

	// ==========================================================
	// pin count of the selected package
	always_comb begin
		case (ctrlPkg_q)
			PKG_32:  pinCount = PINS_32;
			PKG_48:  pinCount = PINS_48;
			default: pinCount = PINS_64;
		endcase
	end

	// ==========================================================
	// enable sequence: idle pins are inputs, enabling walks the default table
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= PMUX_IDLE;
		end else begin
			case (state_q)
				PMUX_IDLE: if (ctrlEn_q) state_q <= PMUX_LOAD;
				PMUX_LOAD: begin
					if (!ctrlEn_q) state_q <= PMUX_IDLE;
					else if (loadWrEn_q && loadWrIdx_q == LAST_PIN) state_q <= PMUX_RUN;
				end
				PMUX_RUN: if (!ctrlEn_q) state_q <= PMUX_IDLE;
				default: state_q <= PMUX_IDLE;
			endcase
		end
	end

	// loader address walk; rom data arrive one cycle after the address
	always_ff @(posedge mclk) begin
		if (rst) begin
			loadCnt_q   <= '0;
			loadWrIdx_q <= '0;
			loadWrEn_q  <= 1'b0;
		end else begin
			loadCnt_q   <= loadIssue ? loadCnt_q + 6'h01 : (stLoad ? loadCnt_q : 6'h00);
			loadWrIdx_q <= loadCnt_q;
			loadWrEn_q  <= loadIssue;
		end
	end

	pmux_default_rom u_rom (
		.mclk     (mclk),
		.rst      (rst),
		.pkgSel   (ctrlPkg_q),
		.addr     (loadCnt_q),
		.rdData_q (romData)
	);

	// ==========================================================
	// write channel capture; address and data may come in either order
	always_ff @(posedge mclk) begin
		if (rst) begin
			awHave_q      <= 1'b0;
			wHave_q       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			awAddr_q      <= '0;
			wData_q       <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q      <= 1'b1;
				awAddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!awHave_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q      <= 1'b1;
				wData_q      <= (s_axi_wstrb == 4'h0) ? 32'h0000_0000 : s_axi_wdata;
				s_axi_wready <= 1'b0;
			end else if (!wHave_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (doWrite) begin
				awHave_q <= 1'b0;
				wHave_q  <= 1'b0;
			end
		end
	end

	// ==========================================================
	// write decode and checks; refused writes change only the refusal flag
	assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
	assign wrPin   = awAddr_q[7:2];
	assign wrIsCfg = awAddr_q[PINCFG_BIT] && (awAddr_q[1:0] == 2'h0) && (wrPin <= LAST_PIN);
	assign wrSel   = wData_q[SEL_W-1:0];
	assign wrVal   = wData_q[CFG_VALID_BIT];
	assign wrDir   = wData_q[CFG_DIR_LSB +: 2];
	// group, pin count, sync FIFO and direction checks; no edits mid load
	assign cfgOk   = !stLoad && (wrPin < pinCount) && (wrDir != 2'h3)
		&& (!wrVal || wrSel[1:0] == wrPin[1:0])
		&& (!wrVal || wrSel < 7'h60)
		&& !(wrVal && ctrlPkg_q == PKG_32 &&
			(wrSel == SIG_FIFO_SYNC0 || wrSel == SIG_FIFO_SYNC1));
	assign ctrlOk  = (wData_q[CTRL_PKG_LSB +: 2] != 2'h3);
	always_comb begin
		if (awAddr_q == ADDR_CTRL) wrOk = ctrlOk;
		else if (awAddr_q == ADDR_STATUS) wrOk = 1'b1;
		else if (wrIsCfg) wrOk = cfgOk;
		else wrOk = 1'b0;
	end

	// control register and sticky refusal flag; a new refusal beats a clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrlEn_q  <= 1'b0;
			ctrlPkg_q <= PKG_RESET;
			reject_q  <= 1'b0;
		end else begin
			if (doWrite && awAddr_q == ADDR_CTRL && ctrlOk) begin
				ctrlEn_q  <= wData_q[CTRL_EN_BIT];
				ctrlPkg_q <= wData_q[CTRL_PKG_LSB +: 2];
			end
			if (doWrite && !wrOk) reject_q <= 1'b1;
			else if (doWrite && awAddr_q == ADDR_STATUS && wData_q[ST_REJECT_BIT]) reject_q <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// per-pin configuration; the loader has the port while loading
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int p = 0; p < NUM_PINS; p++) begin
				cfgSel_q[p] <= SIG_DEBUG;
				cfgVal_q[p] <= 1'b0;
				cfgDir_q[p] <= DIR_IN;
			end
		end else if (stLoad && loadWrEn_q) begin
			cfgSel_q[loadWrIdx_q] <= romData[SEL_W-1:0];
			cfgVal_q[loadWrIdx_q] <= romData[CFG_VALID_BIT];
			cfgDir_q[loadWrIdx_q] <= romData[CFG_DIR_LSB +: 2];
		end else if (doWrite && wrIsCfg && cfgOk) begin
			cfgSel_q[wrPin] <= wrSel;
			cfgVal_q[wrPin] <= wrVal;
			cfgDir_q[wrPin] <= wrDir;
		end
	end

	// ==========================================================
	// read channel
	assign rdPin = s_axi_araddr[7:2];
	always_comb begin
		rdWord = 32'h0000_0000;
		rdOk   = 1'b1;
		if (s_axi_araddr == ADDR_CTRL) begin
			rdWord[CTRL_EN_BIT]          = ctrlEn_q;
			rdWord[CTRL_PKG_LSB +: 2]    = ctrlPkg_q;
		end else if (s_axi_araddr == ADDR_STATUS) begin
			rdWord[ST_LOADING_BIT] = stLoad;
			rdWord[ST_ACTIVE_BIT]  = stRun;
			rdWord[ST_REJECT_BIT]  = reject_q;
		end else if (s_axi_araddr[PINCFG_BIT] && s_axi_araddr[1:0] == 2'h0 && rdPin <= LAST_PIN) begin
			rdWord[CFG_W-1:0] = {cfgDir_q[rdPin], cfgVal_q[rdPin], cfgSel_q[rdPin]};
		end else begin
			rdOk = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdWord;
			s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// pin side: one owner per pin, registered pad drive
	logic [NUM_PINS-1:0] routeIn;
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
			logic drive;
			assign routeIn[gp] = stRun && cfgVal_q[gp] && cfgDir_q[gp] != DIR_OUT;
			// bidirectional pads follow the peripheral's own enable
			assign drive = stRun && cfgVal_q[gp] && (cfgDir_q[gp] == DIR_OUT ||
				(cfgDir_q[gp] == DIR_BIDIR && periphOe[cfgSel_q[gp]]));
			always_ff @(posedge mclk) begin
				if (rst) begin
					pinOut[gp] <= 1'b0;
					pinOeN[gp] <= 1'b1;
				end else begin
					pinOut[gp] <= periphOut[cfgSel_q[gp]];
					pinOeN[gp] <= !drive;
				end
			end

			property p_pinOut;
				@(posedge mclk) disable iff (rst)
				(stRun && cfgVal_q[gp] && cfgDir_q[gp] == DIR_OUT)
				|=> (!pinOeN[gp] && pinOut[gp] == $past(periphOut[cfgSel_q[gp]]));
			endproperty
			a_pinOut: assert property (p_pinOut) else $error("output pad not driven by its signal");
			property p_bidir;
				@(posedge mclk) disable iff (rst)
				(stRun && cfgVal_q[gp] && cfgDir_q[gp] == DIR_BIDIR)
				|=> (pinOeN[gp] == !$past(periphOe[cfgSel_q[gp]]));
			endproperty
			a_bidir: assert property (p_bidir) else $error("bidir pad enable wrong");
			property p_unrouted;
				@(posedge mclk) disable iff (rst)
				(!cfgVal_q[gp] || cfgDir_q[gp] == DIR_IN) |=> pinOeN[gp];
			endproperty
			a_unrouted: assert property (p_unrouted) else $error("unrouted pad driven");
		end
	endgenerate

	// ==========================================================
	// peripheral inputs: lowest numbered owning pin wins, else idle level
	genvar gs;
	generate
		for (gs = 0; gs < NUM_SIGS; gs++) begin : g_sig
			logic valD;
			always_comb begin
				valD = IN_IDLE[gs];
				for (int p = NUM_PINS - 1; p >= 0; p--) begin
					if (routeIn[p] && cfgSel_q[p] == SEL_W'(gs)) valD = pinIn[p];
				end
			end
			always_ff @(posedge mclk) begin
				if (rst) periphIn[gs] <= IN_IDLE[gs];
				else periphIn[gs] <= valD;
			end

			property p_inIdle;
				@(posedge mclk) disable iff (rst)
				!stRun |=> (periphIn[gs] == IN_IDLE[gs]);
			endproperty
			a_inIdle: assert property (p_inIdle) else $error("idle input not at inactive level");
		end
	endgenerate

	// ==========================================================
	// checks on configuration and loading
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_allInput;
		!stRun |=> &pinOeN;
	endproperty
	a_allInput: assert property (p_allInput) else $error("pad driven while disabled");
	property p_group;
		(doWrite && wrIsCfg && wrOk && wrVal) |=> (cfgSel_q[$past(wrPin)][1:0] == $past(wrPin[1:0]));
	endproperty
	a_group: assert property (p_group) else $error("signal stored on wrong group pin");
	property p_pinLimit;
		(doWrite && wrIsCfg && wrPin >= pinCount) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	endproperty
	a_pinLimit: assert property (p_pinLimit) else $error("pin beyond package accepted");
	property p_noSync32;
		(doWrite && wrIsCfg && wrVal && ctrlPkg_q == PKG_32 && wrSel == SIG_FIFO_SYNC0)
		|=> (s_axi_bresp == RESP_SLVERR) ##1 !(cfgVal_q[$past(wrPin, 2)] && cfgSel_q[$past(wrPin, 2)] == SIG_FIFO_SYNC0);
	endproperty
	a_noSync32: assert property (p_noSync32) else $error("sync FIFO accepted on small package");
	property p_loadEnd;
		(stLoad && ctrlEn_q && loadWrEn_q && loadWrIdx_q == LAST_PIN) |=> stRun;
	endproperty
	a_loadEnd: assert property (p_loadEnd) else $error("load did not finish");
	property p_debugDefault;
		(stRun && $past(stLoad)) |-> (cfgVal_q[0] && cfgSel_q[0] == SIG_DEBUG);
	endproperty
	a_debugDefault: assert property (p_debugDefault) else $error("debug not on pin 0");
	property p_fifoDefault;
		(stRun && $past(stLoad) && ctrlPkg_q == PKG_64)
		|-> (cfgSel_q[4] == SIG_FIFO_BASE && cfgSel_q[16] == SIG_FIFO_SYNC0 && cfgVal_q[16]);
	endproperty
	a_fifoDefault: assert property (p_fifoDefault) else $error("FIFO defaults misplaced");
	property p_sizing;
		(stRun && $past(stLoad) && ctrlPkg_q == PKG_48) |-> (!cfgVal_q[28] && cfgVal_q[27]);
	endproperty
	a_sizing: assert property (p_sizing) else $error("48 pin defaults span wrong pins");

	c_loaded: cover property (stLoad ##1 stRun);
	c_refused: cover property (doWrite && !wrOk);
	c_bidirDrive: cover property (stRun && !pinOeN[5] && cfgDir_q[5] == DIR_BIDIR);

endmodule : pmux_top
`default_nettype wire

//--- dv/pmux_ext_pins.sv
// far-side pad model: resolves each pin from pad drive, external drive and pull-up
`timescale 1ns/10ps
`default_nettype none
module pmux_ext_pins
	import pmux_pkg::*;
(
	input  wire logic [NUM_PINS-1:0] pinOut,
	input  wire logic [NUM_PINS-1:0] pinOeN,
	input  wire logic [NUM_PINS-1:0] extVal,
	input  wire logic [NUM_PINS-1:0] extOe,
	output logic      [NUM_PINS-1:0] pinIn
);
	// ==========================================================
	// released pins take the external drive, or else the pull-up, never the last driven value
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pinIn[i] = !pinOeN[i] ? pinOut[i] : (extOe[i] ? extVal[i] : 1'b1);
		end
	end
endmodule : pmux_ext_pins
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the pin multiplexer: register access and pin routing
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import pmux_pkg::*;
;
	logic mclk = 0, rst = 1;
	logic [8:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [NUM_SIGS-1:0] periphOut = 0, periphOe = 0, periphIn;
	logic [NUM_PINS-1:0] pinIn, pinOut, pinOeN, extVal = 0, extOe = 0;
	logic [15:0] rnd = 16'h0c30;
	logic [63:0] rq[$];
	logic [1:0] bq[$];
	int fail_count = 0, cmp_count = 0;

	// ==========================================================
	// clock and instances
	always #20 mclk = ~mclk;
	pmux_top u_pmux_top (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn), .pinIn(pinIn),
		.pinOut(pinOut), .pinOeN(pinOeN));
	pmux_ext_pins u_pmux_ext_pins (.pinOut(pinOut), .pinOeN(pinOeN), .extVal(extVal),
		.extOe(extOe), .pinIn(pinIn));

	// ==========================================================
	// comparison, closing and random source
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// ==========================================================
	// bus master: holds each channel until its own ready
	task axw(input logic [8:0] a, input logic [31:0] d, input logic [1:0] er);
		bq.push_back(er);
		@(posedge mclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		bready <= 0;
	endtask : axw
	task axr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] er);
		rq.push_back({30'h0, er, d});
		@(posedge mclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		rready <= 0;
	endtask : axr
	task step;
		@(posedge mclk);
		@(negedge mclk);
	endtask : step

	// ==========================================================
	// response watcher takes the oldest note whenever an answer lands
	always @(posedge mclk) begin
		if (!rst && rvalid && rready) chk({30'h0, rresp, rdata}, rq.pop_front());
		if (!rst && bvalid && bready) chk({62'h0, bresp}, bq.pop_front());
	end

	// watchdog sized well beyond the few hundred cycles the sequence needs
	initial begin
		#120000;
		fail_count++;
		complete_run();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 0;
		step();
		chk(pinOeN, {NUM_PINS{1'b1}});
		chk(periphIn[63:0], IN_IDLE[63:0]);
		chk(periphIn[95:64], IN_IDLE[95:64]);
		// control reads back disabled with the 64 pin package code
		axr(9'h000, 32'h0000_0004, RESP_OKAY);
		axr(9'h00c, 0, RESP_SLVERR);
		axw(9'h000, 5, RESP_OKAY);
		repeat (50) @(posedge mclk);
		axr(9'h004, 2, RESP_OKAY);
		axr(9'h100, 32'h0000_0280, RESP_OKAY);
		for (int p = 4; p <= 16; p++) axr(9'h100 + 4 * p, 32'h0000_0280 + p + 28, RESP_OKAY);
		// refused writes answer SLVERR and set the sticky refusal flag until a status write clears it
		axw(9'h114, 32'h0000_0184, RESP_SLVERR);
		axw(9'h114, 32'h0000_01e1, RESP_SLVERR);
		axw(9'h114, 32'h0000_0385, RESP_SLVERR);
		axw(9'h008, 1, RESP_SLVERR);
		axw(9'h000, 7, RESP_SLVERR);
		axr(9'h004, 6, RESP_OKAY);
		axw(9'h004, 4, RESP_OKAY);
		axr(9'h004, 2, RESP_OKAY);
		// smallest package: count and sync fifo limits
		axw(9'h000, 1, RESP_OKAY);
		axw(9'h130, 32'h0000_01b0, RESP_SLVERR);
		axw(9'h120, 32'h0000_01ac, RESP_SLVERR);
		axw(9'h124, 32'h0000_01ad, RESP_SLVERR);
		axw(9'h120, 32'h0000_01b0, RESP_OKAY);
		axw(9'h000, 5, RESP_OKAY);
		axw(9'h114, 32'h0000_0185, RESP_OKAY);
		axw(9'h104, 32'h0000_0089, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			@(posedge mclk);
			periphOut <= {6{rnd}};
			periphOe <= {NUM_SIGS{rnd[0]}};
			extVal <= NUM_PINS'({3{rnd}});
			extOe <= 44'h000_0000_0012;
			// extra edge: a bidir pad released now still loops back its old drive for one cycle
			@(posedge mclk);
			step();
			chk(pinOut[5], rnd[5]);
			chk(pinOeN[5], 1'b0);
			chk(periphIn[9], rnd[1]);
			chk(pinOeN[1], 1'b1);
			chk(pinOeN[4], !rnd[0]);
			chk(rnd[0] ? pinOut[4] : periphIn[32], rnd[0] ? rnd[0] : rnd[4]);
			chk(periphIn[95:88], IN_IDLE[95:88]);
		end
		axw(9'h000, 4, RESP_OKAY);
		step();
		step();
		chk(pinOeN, {NUM_PINS{1'b1}});
		// re-enable on the 48 pin package reloads its defaults over earlier edits
		axw(9'h000, 3, RESP_OKAY);
		repeat (50) @(posedge mclk);
		axr(9'h104, 32'h0000_02d9, RESP_OKAY);
		axr(9'h120, 32'h0000_0298, RESP_OKAY);
		axr(9'h16c, 32'h0000_02b3, RESP_OKAY);
		axr(9'h170, 32'h0000_0000, RESP_OKAY);
		axw(9'h170, 32'h0000_0030, RESP_SLVERR);
		axw(9'h000, 2, RESP_OKAY);
		step();
		step();
		chk(pinOeN, {NUM_PINS{1'b1}});
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
